// ==== rtl/wlf_pkg.sv ====
// Function
// - MR1 A7 enters and leaves write leveling
// - MR1 A12 one disables data outputs
// - ODT switches strobe termination only, DQ off
// - DQ undefined on entry until feedback
// - ODT accepted only after tMOD from entry
// - strobe termination on before tWLDQSEN ends
// - rising strobe samples clock, fed back after tWLO
// - feedback bit spread within tWLOE
// - x16 gives separate feedback per byte lane
// - DRAM terminates strobes, controller terminates DQ
// - DQ undefined until tMOD after exit
// - commands after tMOD, MRS after tMRD
package wlf_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int TMOD_NS       = 15;
  localparam int TMOD_MIN_NCK  = 24;
  localparam int TMOD_CLK      = (TMOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMRD_NCK      = 8;
  localparam int TWLO_NS       = 10;
  localparam int TWLO_CLK      = (TWLO_NS / CLK_PERIOD_NS < 1) ? 1 : TWLO_NS / CLK_PERIOD_NS;
  // ==========================================================
  // mode register fields
  localparam int MR1_WL_BIT    = 7;
  localparam int MR1_QOFF_BIT  = 12;
  localparam int MR2_RTTWR_LSB = 9;
  localparam int MR2_RTTWR_MSB = 11;
  localparam logic [2:0] MR_IDX_MR1 = 3'h1;
  localparam logic [2:0] MR_IDX_MR2 = 3'h2;
  // ==========================================================
  // register offsets
  localparam logic [3:0] REG_CFG    = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_VIOL   = 4'h8;
  localparam logic [3:0] REG_MR     = 4'hC;
  // cfg fields and reset values
  localparam int CFG_TMRD_LSB = 0;
  localparam int CFG_TMOD_LSB = 8;
  localparam logic [4:0] CFG_TMRD_RST = 5'h08;
  localparam logic [5:0] CFG_TMOD_RST = 6'h18;
  // status fields
  localparam int ST_WL_POS     = 0;
  localparam int ST_QOFF_POS   = 1;
  localparam int ST_TMOD_POS   = 2;
  localparam int ST_CMDRDY_POS = 3;
  localparam int ST_MRSRDY_POS = 4;
  localparam int ST_DQSTRM_POS = 5;
  localparam int ST_ODT_POS    = 6;
  localparam int ST_FBVAL_POS  = 7;
  localparam int ST_FB_LSB     = 8;
  localparam int ST_DQIN_LSB   = 16;
  // violation bits
  localparam int VIOL_W         = 6;
  localparam int VI_ILLEGAL_CMD = 0;
  localparam int VI_EARLY_CMD   = 1;
  localparam int VI_EARLY_MRS   = 2;
  localparam int VI_EARLY_ODT   = 3;
  localparam int VI_RTT_WR      = 4;
  localparam int VI_EARLY_DQS   = 5;
  // ==========================================================
  // leveling states
  typedef enum logic [3:0] {
    WLF_NORM  = 4'h1,
    WLF_SETUP = 4'h2,
    WLF_LEVEL = 4'h4,
    WLF_EXIT  = 4'h8
  } wlf_state_t;
endpackage

// ==== rtl/wlf_sync.sv ====
`timescale 1ns/100ps
module wlf_sync
  import wlf_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // two flops; first stage read only by second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule

// ==== rtl/wlf_top.sv ====
`timescale 1ns/100ps
module wlf_top
  import wlf_pkg::*;
#(
  parameter int DQ_W = 16
) (
  // clock and reset
  input  wire logic            CLK,
  input  wire logic            RSTN,
  // memory clock and command pins
  input  wire logic            CK_T,
  input  wire logic            CS_N,
  input  wire logic            ACT_N,
  input  wire logic            RAS_N,
  input  wire logic            CAS_N,
  input  wire logic            WE_N,
  input  wire logic [1:0]      BG,
  input  wire logic [1:0]      BA,
  input  wire logic [17:0]     ADDR,
  input  wire logic            ODT,
  // strobes, lower and upper lane
  input  wire logic            LDQS_T,
  input  wire logic            UDQS_T,
  // data pins
  input  wire logic [DQ_W-1:0] DQ_I,
  output logic      [DQ_W-1:0] DQ_O,
  output logic      [DQ_W-1:0] DQ_OE,
  // termination state
  output logic                 DQS_TERM_EN,
  output logic                 DQS_TERM_NOM,
  output logic                 DQ_TERM_EN,
  // mode state
  output logic                 WL_ACTIVE,
  output logic                 CMD_READY,
  output logic                 MRS_READY,
  // register port
  input  wire logic [3:0]      REG_ADDR,
  input  wire logic [31:0]     REG_WDATA,
  input  wire logic            REG_WR,
  input  wire logic            REG_RD,
  output logic      [31:0]     REG_RDATA
);
  localparam int LANES = DQ_W / 8;
  localparam int SW    = 31 + DQ_W;

  // ==========================================================
  // elaboration check
  generate
    if (DQ_W != 8 && DQ_W != 16) begin : g_bad_width
      $error("DQ_W must be 8 or 16");
    end
  endgenerate

  // ==========================================================
  // decode helpers
  function automatic logic is_mrs(input logic [4:0] c);
    // {WE_N, CAS_N, RAS_N, ACT_N, CS_N}: ACT_N high, all others low
    is_mrs = (c == 5'h02);
  endfunction

  function automatic logic mr_hit(input logic [3:0] bgba, input logic [2:0] idx);
    mr_hit = (bgba == {1'b0, idx});
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [SW-1:0] pin_s;

  wlf_sync #(
    .W (SW)
  ) u_sync (
    .clk   (CLK),
    .rst_n (RSTN),
    .d     ({DQ_I, UDQS_T, LDQS_T, ODT, ADDR, BA, BG, WE_N, CAS_N, RAS_N, ACT_N,
             CS_N, CK_T}),
    .q     (pin_s)
  );

  wire             ck_s    = pin_s[0];
  wire [4:0]       cmd_s   = pin_s[5:1];
  wire [3:0]       bgba_s  = {pin_s[7:6], pin_s[9:8]};
  wire [17:0]      addr_s  = pin_s[27:10];
  wire             odt_s   = pin_s[28];
  wire [1:0]       dqs_s   = pin_s[30:29];
  wire [DQ_W-1:0]  dqin_s  = pin_s[SW-1:31];

  // ==========================================================
  // edge detection
  logic       ck_d_ff;
  logic [1:0] dqs_d_ff;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ck_d_ff  <= 1'b0;
      dqs_d_ff <= 2'h0;
    end else begin
      ck_d_ff  <= ck_s;
      dqs_d_ff <= dqs_s;
    end
  end

  wire       ck_rise  = ck_s & ~ck_d_ff;
  wire [1:0] dqs_rise = dqs_s & ~dqs_d_ff;

  // ==========================================================
  // command decode at memory clock edge
  wire cmd_sel   = ck_rise & ~cmd_s[0];
  wire mrs_cmd   = cmd_sel & is_mrs(cmd_s);
  wire mr1_wr    = mrs_cmd & mr_hit(bgba_s, MR_IDX_MR1);
  wire mr2_wr    = mrs_cmd & mr_hit(bgba_s, MR_IDX_MR2);
  wire wl_bit    = addr_s[MR1_WL_BIT];

  // ==========================================================
  // configuration and mode register copies
  logic [4:0]       tmrd_cfg_ff;
  logic [5:0]       tmod_cfg_ff;
  logic [17:0]      mr1_ff;
  logic [2:0]       rtt_wr_ff;
  wlf_state_t       state_ff;
  wlf_state_t       nxt_state;

  wire cfg_wr   = REG_WR & (REG_ADDR == REG_CFG);
  wire viol_wr  = REG_WR & (REG_ADDR == REG_VIOL);
  wire [5:0] tmod_wdata = REG_WDATA[CFG_TMOD_LSB +: 6];
  wire [5:0] nxt_tmod   = (tmod_wdata < CFG_TMOD_RST) ? CFG_TMOD_RST : tmod_wdata;
  wire       qoff       = mr1_ff[MR1_QOFF_BIT];

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tmrd_cfg_ff <= CFG_TMRD_RST;
      tmod_cfg_ff <= CFG_TMOD_RST;
    end else if (cfg_wr) begin
      tmrd_cfg_ff <= REG_WDATA[CFG_TMRD_LSB +: 5];
      tmod_cfg_ff <= nxt_tmod;   // never below 24 clocks
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mr1_ff    <= 18'h00000;
      rtt_wr_ff <= 3'h0;
    end else begin
      if (mr1_wr) begin
        mr1_ff <= addr_s;        // A12 output disable tracked here
      end
      if (mr2_wr) begin
        rtt_wr_ff <= addr_s[MR2_RTTWR_MSB:MR2_RTTWR_LSB];
      end
    end
  end

  // ==========================================================
  // tMOD / tMRD counters restarted by every MRS
  logic [5:0] nck_cnt_ff;
  logic [1:0] clk_cnt_ff;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      nck_cnt_ff <= 6'h3F;
      clk_cnt_ff <= 2'h3;
    end else if (mrs_cmd) begin
      nck_cnt_ff <= 6'h00;
      clk_cnt_ff <= 2'h0;
    end else begin
      if (ck_rise && nck_cnt_ff != 6'h3F) begin
        nck_cnt_ff <= nck_cnt_ff + 6'h01;
      end
      if (clk_cnt_ff != 2'h3) begin
        clk_cnt_ff <= clk_cnt_ff + 2'h1;
      end
    end
  end

  wire tmod_done = (nck_cnt_ff >= tmod_cfg_ff)
                 & (clk_cnt_ff >= 2'(TMOD_CLK));
  wire tmrd_done = ({1'b0, nck_cnt_ff} >= {2'h0, tmrd_cfg_ff});

  // ==========================================================
  // leveling state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      WLF_NORM: begin
        if (mr1_wr && wl_bit) begin
          nxt_state = WLF_SETUP;
        end
      end
      WLF_SETUP: begin
        if (mr1_wr && !wl_bit) begin
          nxt_state = WLF_EXIT;
        end else if (tmod_done) begin
          nxt_state = WLF_LEVEL;
        end
      end
      WLF_LEVEL: begin
        if (mr1_wr && !wl_bit) begin
          nxt_state = WLF_EXIT;
        end
      end
      WLF_EXIT: begin
        if (mr1_wr && wl_bit) begin
          nxt_state = WLF_SETUP;
        end else if (tmod_done) begin
          nxt_state = WLF_NORM;
        end
      end
      default: begin
        nxt_state = WLF_NORM;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= WLF_NORM;
    end else begin
      state_ff <= nxt_state;
    end
  end

  wire in_wl    = (state_ff == WLF_SETUP) | (state_ff == WLF_LEVEL);
  wire leveling = (state_ff == WLF_LEVEL);
  wire drive_wl = in_wl | (state_ff == WLF_EXIT);

  // ==========================================================
  // termination: ODT steers only strobe termination in leveling
  wire odt_eff = odt_s & leveling;
  logic dqs_term_ff;
  logic dqs_nom_ff;
  logic dq_term_ff;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dqs_term_ff <= 1'b0;
      dqs_nom_ff  <= 1'b0;
      dq_term_ff  <= 1'b0;
    end else begin
      dqs_term_ff <= leveling;              // both strobe legs, park or nom
      dqs_nom_ff  <= odt_eff;               // nom when ODT high, park when low
      dq_term_ff  <= odt_s & ~drive_wl;     // DQ termination off in leveling
    end
  end

  // ==========================================================
  // per-lane clock sampling and tWLO delay
  logic [LANES-1:0] fb_ff;
  logic [LANES-1:0] fb_val_ff;

  genvar ln;
  generate
    for (ln = 0; ln < LANES; ln++) begin : g_lane
      logic [TWLO_CLK-1:0] dly_ff;
      logic [TWLO_CLK-1:0] vdly_ff;
      wire                 smp = leveling & dqs_rise[ln];   // own strobe per lane

      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          dly_ff  <= '0;
          vdly_ff <= '0;
        end else begin
          if (smp) begin
            dly_ff[0] <= ck_s;                               // clock level at strobe rise
          end
          vdly_ff[0] <= smp;
          for (int i = 1; i < TWLO_CLK; i++) begin
            dly_ff[i]  <= dly_ff[i-1];
            vdly_ff[i] <= vdly_ff[i-1];
          end
        end
      end

      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          fb_ff[ln]     <= 1'b0;
          fb_val_ff[ln] <= 1'b0;
        end else if (nxt_state == WLF_SETUP && state_ff != WLF_SETUP) begin
          fb_ff[ln]     <= 1'b0;                             // stale value dropped
          fb_val_ff[ln] <= 1'b0;
        end else if (vdly_ff[TWLO_CLK-1]) begin
          fb_ff[ln]     <= dly_ff[TWLO_CLK-1];               // after tWLO
          fb_val_ff[ln] <= 1'b1;
        end
      end

      // all bits of a lane switch in the same cycle
      assign DQ_O[ln*8 +: 8]  = {8{fb_ff[ln] & fb_val_ff[ln] & in_wl}};
      assign DQ_OE[ln*8 +: 8] = {8{drive_wl & ~qoff}};
    end
  endgenerate

  // ==========================================================
  // protocol violation flags, hardware set wins over clear
  wire mr1_legal_wl = mr1_wr & (!wl_bit |
                      ((addr_s ^ mr1_ff) & ~(18'h1 << MR1_QOFF_BIT)) == 18'h0);
  wire [VIOL_W-1:0] viol_set;
  logic [VIOL_W-1:0] viol_ff;

  assign viol_set[VI_ILLEGAL_CMD] = in_wl & cmd_sel & ~mr1_legal_wl;
  assign viol_set[VI_EARLY_CMD]   = cmd_sel & ~is_mrs(cmd_s) & ~tmod_done;
  assign viol_set[VI_EARLY_MRS]   = mrs_cmd & ~tmrd_done;
  assign viol_set[VI_EARLY_ODT]   = (state_ff == WLF_SETUP) & odt_s & ck_rise;
  assign viol_set[VI_RTT_WR]      = in_wl & ~qoff & (rtt_wr_ff != 3'h0);
  assign viol_set[VI_EARLY_DQS]   = (state_ff == WLF_SETUP) & (|dqs_rise);

  wire [VIOL_W-1:0] viol_clr = viol_wr ? REG_WDATA[VIOL_W-1:0] : '0;
  wire [VIOL_W-1:0] nxt_viol = (viol_ff & ~viol_clr) | viol_set;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      viol_ff <= '0;
    end else begin
      viol_ff <= nxt_viol;
    end
  end

  // ==========================================================
  // status outputs
  logic cmd_rdy_ff;
  logic mrs_rdy_ff;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cmd_rdy_ff <= 1'b1;
      mrs_rdy_ff <= 1'b1;
    end else begin
      cmd_rdy_ff <= tmod_done & ~mrs_cmd;
      mrs_rdy_ff <= tmrd_done & ~mrs_cmd;
    end
  end

  assign DQS_TERM_EN  = dqs_term_ff;
  assign DQS_TERM_NOM = dqs_nom_ff;
  assign DQ_TERM_EN   = dq_term_ff;
  assign WL_ACTIVE    = in_wl;
  assign CMD_READY    = cmd_rdy_ff;
  assign MRS_READY    = mrs_rdy_ff;

  // ==========================================================
  // register read port, data one cycle after strobe
  logic [31:0] status_w;
  logic [31:0] rdata_ff;

  always_comb begin
    status_w                     = 32'h00000000;
    status_w[ST_WL_POS]          = in_wl;
    status_w[ST_QOFF_POS]        = qoff;
    status_w[ST_TMOD_POS]        = tmod_done;
    status_w[ST_CMDRDY_POS]      = cmd_rdy_ff;
    status_w[ST_MRSRDY_POS]      = mrs_rdy_ff;
    status_w[ST_DQSTRM_POS]      = dqs_term_ff;
    status_w[ST_ODT_POS]         = odt_eff;
    status_w[ST_FBVAL_POS]       = &fb_val_ff;
    status_w[ST_FB_LSB +: LANES] = fb_ff;
    status_w[ST_DQIN_LSB +: 8]   = dqin_s[7:0];
  end

  wire [31:0] cfg_w = {18'h00000, tmod_cfg_ff, 3'h0, tmrd_cfg_ff};
  wire [31:0] rsel  = (REG_ADDR == REG_CFG)    ? cfg_w :
                      (REG_ADDR == REG_STATUS) ? status_w :
                      (REG_ADDR == REG_VIOL)   ? {{(32-VIOL_W){1'b0}}, viol_ff} :
                      (REG_ADDR == REG_MR)     ? {11'h000, rtt_wr_ff, mr1_ff} :
                                                 32'h00000000;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_ff <= 32'h00000000;
    end else if (REG_RD) begin
      rdata_ff <= rsel;
    end else begin
      rdata_ff <= 32'h00000000;
    end
  end

  assign REG_RDATA = rdata_ff;
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
module testbench
  import wlf_pkg::*;
;
  localparam int         DQ_W = 16;
  localparam logic [4:0] MRS  = 5'h08;
  logic            clk = 1'b0;
  logic            rstn = 1'b0;
  wire             ck_t, cs_n, act_n, ras_n, cas_n, we_n, odt, ldqs_t, udqs_t;
  logic            fb;
  wire  [1:0]      bg, ba;
  wire  [17:0]     addr;
  wire  [DQ_W-1:0] dq_i;
  logic [DQ_W-1:0] dq_o, dq_oe;
  logic            dqs_term_en, dqs_term_nom, dq_term_en, wl_active, cmd_ready, mrs_ready;
  logic [5:0]      st;
  logic [3:0]      reg_addr = 4'h0;
  logic [31:0]     reg_wdata = 32'h0;
  logic [31:0]     reg_rdata, v;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  int              n_fail = 0;
  int              comparisons = 0;
  int              lock;
  always #2.5 clk = ~clk;
  // released dq bits pulled high by controller termination
  assign dq_i = dq_o | ~dq_oe;
  assign st = {wl_active, cmd_ready, mrs_ready, dqs_term_en, dqs_term_nom, dq_term_en};
  wlf_top #(.DQ_W(DQ_W)) i_wlf_top (
    .CLK(clk), .RSTN(rstn), .CK_T(ck_t), .CS_N(cs_n), .ACT_N(act_n), .RAS_N(ras_n),
    .CAS_N(cas_n), .WE_N(we_n), .BG(bg), .BA(ba), .ADDR(addr), .ODT(odt),
    .LDQS_T(ldqs_t), .UDQS_T(udqs_t), .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE(dq_oe),
    .DQS_TERM_EN(dqs_term_en), .DQS_TERM_NOM(dqs_term_nom), .DQ_TERM_EN(dq_term_en),
    .WL_ACTIVE(wl_active), .CMD_READY(cmd_ready), .MRS_READY(mrs_ready),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata));
  wlf_ctl #(.DQ_W(DQ_W)) i_wlf_ctl (
    .ck_t(ck_t), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bg(bg), .ba(ba), .addr(addr), .odt(odt), .ldqs_t(ldqs_t), .udqs_t(udqs_t), .dq_i(dq_i));
  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #60000;
    n_fail++;
    tally_and_finish();
  end
  // ==========================================================
  // tests
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    check("reset state", 32'(st), 32'h18);
    check("reset oe", 32'(dq_oe), 32'h0);
    rd(REG_CFG, v);
    check("cfg", v, 32'h0000_1808);
    rd(4'h2, v);
    check("unmapped", v, 32'h0);
    wr(REG_CFG, 32'h0000_0305);
    rd(REG_CFG, v);
    check("cfg clamp", v, 32'h0000_1805);
    i_wlf_ctl.cmd(MRS, MR_IDX_MR1, 18'h00080);
    check("entry state", 32'(st), 32'h20);
    check("entry oe", 32'(dq_oe), 32'({DQ_W{1'b1}}));
    i_wlf_ctl.set_odt(1'b1);
    i_wlf_ctl.pulse(0, 45, fb);
    check("early fb", 32'(dq_o), 32'h0);
    check("early term", 32'(dqs_term_en), 32'h0);
    i_wlf_ctl.set_odt(1'b0);
    rd(REG_VIOL, v);
    check("viol early", v & 32'h28, 32'h28);
    wr(REG_VIOL, 32'h3F);
    rd(REG_VIOL, v);
    check("viol clear", v, 32'h0);
    // odt and strobes only after tMOD
    i_wlf_ctl.wait_ck(26);
    check("level park", 32'(st), 32'h3C);
    i_wlf_ctl.set_odt(1'b1);
    i_wlf_ctl.wait_ck(1);
    check("level nom", 32'(st), 32'h3E);
    i_wlf_ctl.sweep(0, lock);
    check("lock delay", 32'(lock), 32'h2D);
    check("lane0 fb", 32'(dq_o), 32'h00FF);
    i_wlf_ctl.pulse(1, 45, fb);
    i_wlf_ctl.pulse(0, 5, fb);
    check("lanes fb", 32'(dq_o), 32'hFF00);
    rd(REG_STATUS, v);
    check("fb status", 32'(v[9:7]), 32'h5);
    i_wlf_ctl.cmd(MRS, MR_IDX_MR2, 18'h00200);
    rd(REG_VIOL, v);
    check("viol rtt_wr", v & 32'h10, 32'h10);
    wr(REG_VIOL, 32'h3F);
    i_wlf_ctl.wait_ck(8);
    i_wlf_ctl.cmd(MRS, MR_IDX_MR1, 18'h01080);
    check("qoff oe", 32'(dq_oe), 32'h0);
    check("qoff stays", 32'(wl_active), 32'h1);
    i_wlf_ctl.wait_ck(26);
    i_wlf_ctl.cmd(5'h07, 3'h0, 18'h0);
    rd(REG_VIOL, v);
    check("viol command", v & 32'h1, 32'h1);
    i_wlf_ctl.wait_ck(8);
    i_wlf_ctl.cmd(MRS, MR_IDX_MR1, 18'h00080);
    i_wlf_ctl.wait_ck(26);
    i_wlf_ctl.set_odt(1'b0);
    i_wlf_ctl.wait_ck(2);
    check("pre exit", 32'(st), 32'h3C);
    i_wlf_ctl.cmd(MRS, MR_IDX_MR1, 18'h00000);
    check("exit state", 32'(st), 32'h00);
    check("exit oe", 32'(dq_oe), 32'({DQ_W{1'b1}}));
    i_wlf_ctl.wait_ck(9);
    check("mrs ready", 32'(st), 32'h08);
    i_wlf_ctl.wait_ck(16);
    check("cmd ready", 32'(st), 32'h18);
    check("oe released", 32'(dq_oe), 32'h0);
    tally_and_finish();
  end
endmodule
bind wlf_top wlf_monitor #(.DQ_W(DQ_W)) i_wlf_monitor (
  .CLK(CLK), .RSTN(RSTN), .ODT(ODT), .REG_RD(REG_RD), .DQ_O(DQ_O), .DQ_OE(DQ_OE),
  .DQS_TERM_EN(DQS_TERM_EN), .DQS_TERM_NOM(DQS_TERM_NOM), .DQ_TERM_EN(DQ_TERM_EN),
  .WL_ACTIVE(WL_ACTIVE), .CMD_READY(CMD_READY), .MRS_READY(MRS_READY),
  .REG_RDATA(REG_RDATA));

// ==== sim/wlf_ctl.sv ====
`timescale 1ns/100ps
module wlf_ctl
  import wlf_pkg::*;
#(
  parameter int DQ_W = 16
) (
  // memory clock and command
  output logic            ck_t,
  output logic            cs_n,
  output logic            act_n,
  output logic            ras_n,
  output logic            cas_n,
  output logic            we_n,
  output logic [1:0]      bg,
  output logic [1:0]      ba,
  output logic [17:0]     addr,
  output logic            odt,
  // strobes and feedback
  output logic            ldqs_t,
  output logic            udqs_t,
  input  wire logic [DQ_W-1:0] dq_i
);
  initial begin
    {cs_n, act_n, ras_n, cas_n, we_n} = 5'h1F;
    {bg, ba, addr, odt, ldqs_t, udqs_t} = 25'h0;
    ck_t = 1'b0;
    #17.3;
    forever #40 ck_t = ~ck_t;
  end
  // one command for one clock, then deselect
  task automatic cmd(input logic [4:0] pins, input logic [2:0] mr, input logic [17:0] a);
    @(negedge ck_t);
    {cs_n, act_n, ras_n, cas_n, we_n} <= pins;
    {bg, ba} <= {1'b0, mr};
    addr <= a;
    @(negedge ck_t);
    cs_n <= 1'b1;
    addr <= ~a;
  endtask
  task automatic wait_ck(input int n);
    repeat (n) @(posedge ck_t);
  endtask
  task automatic set_odt(input logic v);
    @(negedge ck_t);
    odt <= v;
  endtask
  // single rising edge d ns after clock fall, high 40 ns
  task automatic pulse(input int lane, input int d, output logic fb);
    @(negedge ck_t);
    #(d);
    {udqs_t, ldqs_t} <= (lane == 0) ? 2'b01 : 2'b10;
    #40;
    {udqs_t, ldqs_t} <= 2'b00;
    repeat (2) @(posedge ck_t);
    fb = dq_i[lane * 8];
  endtask
  // step the delay until feedback goes 0 to 1, then lock
  task automatic sweep(input int lane, output int lock);
    logic fb;
    lock = 5;
    pulse(lane, lock, fb);
    while (fb !== 1'b1 && lock < 75) begin
      lock = lock + 10;
      pulse(lane, lock, fb);
    end
  endtask
endmodule

// ==== sim/wlf_monitor.sv ====
`timescale 1ns/100ps
module wlf_monitor
  import wlf_pkg::*;
#(
  parameter int DQ_W = 16
) (
  // clock and reset
  input wire logic            CLK,
  input wire logic            RSTN,
  // watched pins
  input wire logic            ODT,
  input wire logic            REG_RD,
  input wire logic [DQ_W-1:0] DQ_O,
  input wire logic [DQ_W-1:0] DQ_OE,
  input wire logic            DQS_TERM_EN,
  input wire logic            DQS_TERM_NOM,
  input wire logic            DQ_TERM_EN,
  input wire logic            WL_ACTIVE,
  input wire logic            CMD_READY,
  input wire logic            MRS_READY,
  input wire logic [31:0]     REG_RDATA
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // ==========================================================
  // exit steps
  sequence s_exit;
    $fell(WL_ACTIVE);
  endsequence
  sequence s_oe_exit;
    s_exit ##0 DQ_OE[0];
  endsequence
  // ==========================================================
  // termination
  a_dq_term_off: assert property (WL_ACTIVE && $past(WL_ACTIVE) |-> !DQ_TERM_EN)
    else $error("dq termination on during leveling");
  a_strobe_term_only: assert property (DQS_TERM_EN |-> !DQ_TERM_EN)
    else $error("dq termination on beside strobe termination");
  a_nom_follows_odt: assert property (ODT [*6] ##0 DQS_TERM_EN |-> DQS_TERM_NOM)
    else $error("strobe termination not nominal with odt high");
  a_term_in_level: assert property (DQS_TERM_EN |-> WL_ACTIVE || $past(WL_ACTIVE))
    else $error("strobe termination outside leveling");
  // ==========================================================
  // feedback and outputs
  a_oe_in_level: assert property ($rose(DQ_OE[0]) |-> WL_ACTIVE || $past(WL_ACTIVE))
    else $error("dq driven outside leveling");
  a_lane_low_even: assert property (DQ_O[7:0] == 8'h00 || DQ_O[7:0] == 8'hFF)
    else $error("lower lane feedback bits differ");
  a_lane_high_even: assert property (DQ_O[DQ_W-1 -: 8] == 8'h00 || DQ_O[DQ_W-1 -: 8] == 8'hFF)
    else $error("upper lane feedback bits differ");
  a_oe_holds_exit: assert property (s_oe_exit |-> DQ_OE[0] [*8])
    else $error("dq released early after exit");
  // ==========================================================
  // command readiness and register port
  a_exit_not_ready: assert property (s_exit |-> ##[0:1] !CMD_READY)
    else $error("command ready right after exit");
  a_ready_order: assert property (CMD_READY |-> MRS_READY)
    else $error("command ready before mode register ready");
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data outside answer cycle");
endmodule
